/* design/tss_pkg.sv */
package tss_pkg;

  // Register offsets, relative to the status I/O base
  localparam logic [7:0] OFS_STATUS_MIRROR = 8'h00;
  localparam logic [7:0] OFS_STATUS_TOP = 8'h02;

  // Bit positions of the top-level status word
  localparam int BIT_PME = 0;
  localparam int BIT_AUDIO = 1;
  localparam int BIT_ACPI = 2;
  localparam int BIT_LPC = 3;
  localparam int BIT_RSVD = 4;
  localparam int BIT_VID_RETRACE = 5;
  localparam int BIT_VGA_TIMER = 6;
  localparam int BIT_A20 = 7;
  localparam int BIT_SOFTWARE = 8;
  localparam int BIT_TIMER_TRAP = 9;
  localparam int BIT_EXT_PIN = 10;
  localparam int BIT_SIO_IRQ = 11;
  localparam int BIT_NMI = 12;
  localparam int BIT_WARM_RESET = 13;
  localparam int BIT_USB = 14;
  localparam int BIT_SUSP_MIRROR = 15;

  // Serial link status bit that carries the retrace event
  localparam int LINK_RETRACE_BIT = 7;

  // Field groups of the status word
  localparam logic [15:0] MASK_READ_CLEAR = 16'h71E0;
  localparam logic [15:0] MASK_LEVEL_TWO = 16'h0A0F;
  localparam logic [15:0] MASK_PIN = 16'h0400;
  localparam logic [15:0] MASK_LIVE = 16'h8000;
  localparam logic [15:0] MASK_RESERVED = 16'h0010;
  localparam logic [15:0] MASK_SMI_CAUSE = 16'h7FEF;

  // Reset values
  localparam logic [15:0] RST_STATUS = 16'h0000;
  localparam logic [7:0] RST_PIN_STATUS = 8'h00;
  localparam logic [15:0] RST_RD_DATA = 16'h0000;

  // Widths
  localparam int PIN_COUNT = 8;
  localparam int LINK_WIDTH = 8;

  // Source event pulses, one cycle each
  typedef struct packed {
    logic usbEvent;
    logic warmResetEvent;
    logic nmiEvent;
    logic sioIrqEvent;
    logic softwareEvent;
    logic a20Event;
    logic vgaTimerEvent;
    logic lpcEvent;
    logic acpiAccessEvent;
    logic audioEvent;
    logic pmeEvent;
    logic [1:0] gpTimerExpired;
    logic [2:0] userTrapHit;
    logic functionTrapHit;
  } tss_src_s;

  // Second-level clear pulses, one cycle each
  typedef struct packed {
    logic sioIrqClear;
    logic timerTrapClear;
    logic lpcClear;
    logic acpiClear;
    logic audioClear;
    logic pmeClear;
  } tss_clr_s;

  // Configuration levels
  typedef struct packed {
    logic suspModEnable;
    logic vidRetraceEnable;
    logic vgaTimerEnable;
  } tss_cfg_s;

endpackage

/* design/tss_pin_status.sv */
`timescale 1ns/10ps
module tss_pin_status
  import tss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [PIN_COUNT-1:0] pinEvent,
  input wire logic [PIN_COUNT-1:0] pinThirdClear,
  output logic [PIN_COUNT-1:0] pinStatus,
  output logic pinAny
);

  typedef struct packed {
    logic [PIN_COUNT-1:0] flags;
  } tss_pin_state_s;

  tss_pin_state_s state_reg;
  tss_pin_state_s state_next;

  // Per-pin second-level flag; a new edge wins over a clear
  always_comb begin
    state_next = state_reg;
    state_next.flags = (state_reg.flags & ~pinThirdClear) | pinEvent;
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg.flags <= RST_PIN_STATUS;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pinStatus = state_reg.flags;
  assign pinAny = |state_reg.flags;

endmodule

/* design/tss_top.sv */
`timescale 1ns/10ps
//
// Contract
// - Sixteen-bit top status register at offset 02h, mixed read-only and read-to-clear.
// - Reading the top register clears read-to-clear flags, leaves read-only flags.
// - Second-level clear also clears its top flag, except pin sources.
// - Pin third-level clear clears the second-level and top flags.
// - Mirror at offset 00h reads the same value without clearing anything.
// - Bit 15 shows the live suspend-modulation configuration bit.
// - Warm-reset command sets its own read-to-clear flag.
// - Bit 5 flags video retrace decoded from serial link status bit 7.
// - Video retrace source fires only while its enable bit is one.
// - Timer source in bit 6 fires only while its enable bit is one.
// - Bit 4 is reserved and always reads zero.
// - Bit 3 flags low-pin-count bus interface interrupts.
// - Bit 2 flags accesses to the ACPI register block.
// - Bit 1 flags audio subsystem interrupts.
// - Bit 0 flags power-management events other than bit 9 sources.
// - Bit 6 flags expiry of the video-graphics timer.
// - Bit 9 flags general timers, user-defined traps and function traps.
module tss_top
  import tss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ioRdStrobe,
  input wire logic [7:0] ioAddr,
  output logic [15:0] ioRdData,
  output logic ioRdValid,
  input wire tss_cfg_s cfgLevels,
  input wire logic [LINK_WIDTH-1:0] processor_serial_link_status,
  input wire tss_src_s srcEvents,
  input wire tss_clr_s levelTwoClear,
  input wire logic [PIN_COUNT-1:0] pinEvent,
  input wire logic [PIN_COUNT-1:0] pinThirdClear,
  output logic [PIN_COUNT-1:0] pinStatus,
  output logic smiRequest
);

  // Whole state of the block except the pin flags held in u_pin_status
  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] rdData;
    logic rdValid;
    logic retracePrev;
    logic smiActive;
  } tss_state_s;

  tss_state_s state_reg;
  tss_state_s state_next;

  // Vectors by bit position
  logic [15:0] setVec;
  logic [15:0] rdClrVec;
  logic [15:0] lowClrVec;
  logic [15:0] flagsNext;
  logic [15:0] viewWord;
  logic [15:0] rdDataNext;
  logic [15:0] causeVec;
  logic smiNext;

  // Decode and source helpers
  logic readTop;
  logic readMirror;
  logic readAny;
  logic retraceNow;
  logic retraceEdge;
  logic timerTrapHit;
  logic pinClearHit;

  // Per-source set terms
  logic pmeSet;
  logic audioSet;
  logic acpiSet;
  logic lpcSet;
  logic retraceSet;
  logic vgaTimerSet;
  logic a20Set;
  logic softwareSet;
  logic timerTrapSet;
  logic extPinSet;
  logic sioIrqSet;
  logic nmiSet;
  logic warmResetSet;
  logic usbSet;

  // Read-to-clear terms, one per read-to-clear bit
  logic retraceRdClr;
  logic vgaTimerRdClr;
  logic a20RdClr;
  logic softwareRdClr;
  logic nmiRdClr;
  logic warmResetRdClr;
  logic usbRdClr;

  // Lower-level clear terms, one per read-only bit
  logic pmeLowClr;
  logic audioLowClr;
  logic acpiLowClr;
  logic lpcLowClr;
  logic timerTrapLowClr;
  logic extPinLowClr;
  logic sioIrqLowClr;

  // Second-level store of the pin-originated sources
  tss_pin_status u_pin_status (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pinEvent(pinEvent),
    .pinThirdClear(pinThirdClear),
    .pinStatus(pinStatus),
    .pinAny()
  );

  // Top offset; both bytes of the word select it
  assign readTop = ioRdStrobe && (ioAddr[7:1] == OFS_STATUS_TOP[7:1]);
  // Mirror offset, same word without side effects
  assign readMirror = ioRdStrobe && (ioAddr[7:1] == OFS_STATUS_MIRROR[7:1]);
  // Every strobe is answered, unmapped offsets with zero
  assign readAny = ioRdStrobe;

  // Retrace level from the link, sampled every cycle
  assign retraceNow = processor_serial_link_status[LINK_RETRACE_BIT];

  // Rising edge only, so a held level fires once
  assign retraceEdge = retraceNow && !state_reg.retracePrev;

  // Bit 9 gathers timers and both kinds of trap
  assign timerTrapHit = (|srcEvents.gpTimerExpired)
    || (|srcEvents.userTrapHit)
    || srcEvents.functionTrapHit;

  // Any third-level pin clear counts for the top pin flag
  assign pinClearHit = |pinThirdClear;

  // Bit 0: power-management events outside bit 9
  assign pmeSet = srcEvents.pmeEvent;

  // Cleared at its second level
  assign pmeLowClr = levelTwoClear.pmeClear;

  // Bit 1: audio subsystem
  assign audioSet = srcEvents.audioEvent;

  // Cleared at its second level
  assign audioLowClr = levelTwoClear.audioClear;

  // Bit 2: accesses to the ACPI register block
  assign acpiSet = srcEvents.acpiAccessEvent;

  // Cleared at its second level
  assign acpiLowClr = levelTwoClear.acpiClear;

  // Bit 3: low-pin-count bus interface
  assign lpcSet = srcEvents.lpcEvent;

  // Cleared at its second level
  assign lpcLowClr = levelTwoClear.lpcClear;

  // Bit 5: retrace, gated by its enable level
  assign retraceSet = retraceEdge && cfgLevels.vidRetraceEnable;

  // Cleared by a top read
  assign retraceRdClr = readTop;

  // Bit 6: graphics timer, gated by its enable level
  assign vgaTimerSet = srcEvents.vgaTimerEvent && cfgLevels.vgaTimerEnable;

  // Cleared by a top read
  assign vgaTimerRdClr = readTop;

  // Bit 7: address-line toggle
  assign a20Set = srcEvents.a20Event;

  // Cleared by a top read
  assign a20RdClr = readTop;

  // Bit 8: software-generated
  assign softwareSet = srcEvents.softwareEvent;

  // Cleared by a top read
  assign softwareRdClr = readTop;

  // Bit 9: timers and traps
  assign timerTrapSet = timerTrapHit;

  // Cleared at its second level
  assign timerTrapLowClr = levelTwoClear.timerTrapClear;

  // Bit 10: pin sources
  assign extPinSet = |pinEvent;

  // Any third-level clear; second-level clears never reach here
  assign extPinLowClr = pinClearHit;

  // Bit 11: super I/O interrupt line
  assign sioIrqSet = srcEvents.sioIrqEvent;

  // Cleared at its second level
  assign sioIrqLowClr = levelTwoClear.sioIrqClear;

  // Bit 12: non-maskable interrupt
  assign nmiSet = srcEvents.nmiEvent;

  // Cleared by a top read
  assign nmiRdClr = readTop;

  // Bit 13: warm-reset command
  assign warmResetSet = srcEvents.warmResetEvent;

  // Cleared by a top read
  assign warmResetRdClr = readTop;

  // Bit 14: USB activity
  assign usbSet = srcEvents.usbEvent;

  // Cleared by a top read
  assign usbRdClr = readTop;

  // Gather set terms by bit position
  always_comb begin
    setVec = 16'h0000;
    // Second-level sources
    setVec[BIT_PME] = pmeSet;
    setVec[BIT_AUDIO] = audioSet;
    setVec[BIT_ACPI] = acpiSet;
    setVec[BIT_LPC] = lpcSet;
    setVec[BIT_TIMER_TRAP] = timerTrapSet;
    setVec[BIT_SIO_IRQ] = sioIrqSet;
    // Read-to-clear sources
    setVec[BIT_VID_RETRACE] = retraceSet;
    setVec[BIT_VGA_TIMER] = vgaTimerSet;
    setVec[BIT_A20] = a20Set;
    setVec[BIT_SOFTWARE] = softwareSet;
    setVec[BIT_NMI] = nmiSet;
    setVec[BIT_WARM_RESET] = warmResetSet;
    setVec[BIT_USB] = usbSet;
    // Pin source
    setVec[BIT_EXT_PIN] = extPinSet;
  end

  // Gather read-to-clear terms; the rest stay zero
  always_comb begin
    rdClrVec = 16'h0000;
    rdClrVec[BIT_VID_RETRACE] = retraceRdClr;
    rdClrVec[BIT_VGA_TIMER] = vgaTimerRdClr;
    rdClrVec[BIT_A20] = a20RdClr;
    rdClrVec[BIT_SOFTWARE] = softwareRdClr;
    rdClrVec[BIT_NMI] = nmiRdClr;
    rdClrVec[BIT_WARM_RESET] = warmResetRdClr;
    rdClrVec[BIT_USB] = usbRdClr;
  end

  // Gather lower-level clear terms
  always_comb begin
    lowClrVec = 16'h0000;
    lowClrVec[BIT_PME] = pmeLowClr;
    lowClrVec[BIT_AUDIO] = audioLowClr;
    lowClrVec[BIT_ACPI] = acpiLowClr;
    lowClrVec[BIT_LPC] = lpcLowClr;
    lowClrVec[BIT_TIMER_TRAP] = timerTrapLowClr;
    lowClrVec[BIT_EXT_PIN] = extPinLowClr;
    lowClrVec[BIT_SIO_IRQ] = sioIrqLowClr;
  end

  // Per-bit flag update; a set in the clear cycle is kept
  for (genvar i = 0; i < 16; i++) begin : g_flag
    if (MASK_READ_CLEAR[i]) begin : g_rd
      // Dropped by a top read only
      assign flagsNext[i] = (state_reg.flags[i] && !rdClrVec[i]) || setVec[i];
    end else if (MASK_LEVEL_TWO[i]) begin : g_low
      // Dropped by its second-level clear only
      assign flagsNext[i] = (state_reg.flags[i] && !lowClrVec[i]) || setVec[i];
    end else if (MASK_PIN[i]) begin : g_pin
      // Dropped by a third-level pin clear only
      assign flagsNext[i] = (state_reg.flags[i] && !lowClrVec[i]) || setVec[i];
    end else begin : g_none
      // Live or reserved bits hold no flag
      assign flagsNext[i] = 1'b0;
    end
  end

  // Word shown by both read offsets, built bit by bit
  for (genvar j = 0; j < 16; j++) begin : g_view
    if (j == BIT_SUSP_MIRROR) begin : g_live
      // Live configuration level, never stored
      assign viewWord[j] = cfgLevels.suspModEnable;
    end else if (j == BIT_RSVD) begin : g_rsvd
      // Reserved position
      assign viewWord[j] = 1'b0;
    end else begin : g_stored
      // Stored flag
      assign viewWord[j] = state_reg.flags[j];
    end
  end

  // Read answer holds the word before this read's own clear
  always_comb begin
    rdDataNext = RST_RD_DATA;
    if (readTop || readMirror) begin
      rdDataNext = viewWord;
    end
  end

  // Request causes; live and reserved bits never count
  assign causeVec = flagsNext & MASK_SMI_CAUSE;
  assign smiNext = |causeVec;

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    // Edge history of the retrace bit
    state_next.retracePrev = retraceNow;
    state_next.flags = flagsNext;
    state_next.rdValid = readAny;
    state_next.rdData = rdDataNext;
    // Request follows the next flags, so it drops on the clearing edge
    state_next.smiActive = smiNext;
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg.flags <= RST_STATUS;
      state_reg.rdData <= RST_RD_DATA;
      state_reg.rdValid <= 1'b0;
      state_reg.retracePrev <= 1'b0;
      state_reg.smiActive <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Read answer straight from flops
  assign ioRdData = state_reg.rdData;
  assign ioRdValid = state_reg.rdValid;

  // Request straight from a flop
  assign smiRequest = state_reg.smiActive;

endmodule

/* tb/tss_chk_sva.sv */
`timescale 1ns/10ps
module tss_chk
  import tss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ioRdStrobe,
  input wire logic [7:0] ioAddr,
  input wire logic [15:0] ioRdData,
  input wire logic ioRdValid,
  input wire tss_cfg_s cfgLevels,
  input wire tss_src_s srcEvents,
  input wire logic [LINK_WIDTH-1:0] processor_serial_link_status,
  input wire logic [PIN_COUNT-1:0] pinEvent,
  input wire logic [PIN_COUNT-1:0] pinStatus,
  input wire logic smiRequest
);
  // No source pulse and no retrace level this cycle
  logic quiet;
  assign quiet = (srcEvents == '0) && !processor_serial_link_status[LINK_RETRACE_BIT];
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Read answer timing and idle bus
  rd_answer_a: assert property (ioRdStrobe |=> ioRdValid)
    else $error("read not answered");
  rd_only_a: assert property (!ioRdStrobe |=> !ioRdValid)
    else $error("stray answer");
  idle_zero_a: assert property (!ioRdValid |-> ioRdData == 16'h0)
    else $error("stray data");
  rsvd_zero_a: assert property (ioRdValid |-> !ioRdData[BIT_RSVD])
    else $error("reserved bit set");
  susp_live_a: assert property (ioRdStrobe && ioAddr < 8'h04
    |=> ioRdData[15] == $past(cfgLevels.suspModEnable)) else $error("bit 15 stale");
  // Second top read with no pulse in between sees no read-to-clear flag
  rd_clear_a: assert property (quiet ##1 ioRdStrobe && ioAddr[7:1] == 7'h01 && quiet
    ##1 quiet ##1 ioRdStrobe |=> (ioRdData & MASK_READ_CLEAR) == 16'h0) else $error("flag survived read");
  warm_smi_a: assert property (srcEvents.warmResetEvent |=> smiRequest)
    else $error("no request");
  pin_set_a: assert property (|pinEvent |=> (pinStatus & $past(pinEvent)) == $past(pinEvent))
    else $error("pin flag missing");
  cover property (srcEvents.warmResetEvent);
  cover property (|pinEvent);
  cover property (ioRdValid && ioRdData[15]);
endmodule

bind tss_top tss_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .ioRdStrobe(ioRdStrobe), .ioAddr(ioAddr),
  .ioRdData(ioRdData), .ioRdValid(ioRdValid), .cfgLevels(cfgLevels), .srcEvents(srcEvents),
  .processor_serial_link_status(processor_serial_link_status),
  .pinEvent(pinEvent), .pinStatus(pinStatus), .smiRequest(smiRequest));

/* tb/tss_host_model.sv */
`timescale 1ns/10ps
module tss_host_model
  import tss_pkg::*;
(
  input wire logic sys_clk,
  output logic ioRdStrobe = 1'b0,
  output logic [7:0] ioAddr = 8'h00,
  output tss_cfg_s cfgLevels = '0
);
  // One-cycle strobe per read; offset is driven to its complement once released
  task automatic rd(logic [7:0] a);
    @(posedge sys_clk);
    ioRdStrobe <= 1'b1;
    ioAddr <= a;
    @(posedge sys_clk);
    ioRdStrobe <= 1'b0;
    ioAddr <= ~a;
  endtask
  // Handler sets source enables before relying on them
  task automatic cfg(tss_cfg_s c);
    @(posedge sys_clk);
    cfgLevels <= c;
  endtask
endmodule

/* tb/top_level_smi_status_tb.sv */
`timescale 1ns/10ps
module top_level_smi_status_tb;
  import tss_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ioRdStrobe, ioRdValid, smiRequest;
  logic [7:0] ioAddr, pinStatus, pat, link = 8'h00, pinEv = 8'h00, pinClr = 8'h00;
  logic [15:0] ioRdData;
  logic [15:0] expq[$];
  logic [31:0] rs = 32'h0000_c234;
  tss_cfg_s cfgLevels;
  tss_src_s src = '0;
  tss_clr_s l2c = '0;
  int fail_count = 0;
  int compares = 0;
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  tss_host_model host_u (.sys_clk(sys_clk), .ioRdStrobe(ioRdStrobe), .ioAddr(ioAddr), .cfgLevels(cfgLevels));
  tss_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .ioRdStrobe(ioRdStrobe), .ioAddr(ioAddr), .ioRdData(ioRdData),
    .ioRdValid(ioRdValid), .cfgLevels(cfgLevels), .processor_serial_link_status(link), .srcEvents(src),
    .levelTwoClear(l2c), .pinEvent(pinEv), .pinThirdClear(pinClr), .pinStatus(pinStatus), .smiRequest(smiRequest));
  function automatic logic [31:0] xs(logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Expected word is queued before the strobe goes out
  task automatic rdx(logic [7:0] a, logic [15:0] e);
    expq.push_back(e);
    host_u.rd(a);
  endtask
  task automatic smi(logic e);
    @(negedge sys_clk);
    chk("smiRequest", 16'(smiRequest), 16'(e));
  endtask
  // Each answer is matched to the oldest queued word
  always @(negedge sys_clk) begin
    if (ioRdValid === 1'b1) chk("ioRdData", ioRdData, expq.pop_front());
  end
  // One-cycle pulse for the source behind status bit b
  task automatic fire(int b);
    @(posedge sys_clk);
    case (b)
      0, 1, 2, 3: src[6 + b] <= 1'b1;
      6, 7, 8: src[4 + b] <= 1'b1;
      11, 12, 13, 14: src[2 + b] <= 1'b1;
      5: link <= {1'b1, rs[6:0]};
      9: src[rs[2:0] % 6] <= 1'b1;
      default: pinEv <= pat;
    endcase
    @(posedge sys_clk);
    src <= '0;
    link <= 8'h00;
    pinEv <= 8'h00;
    repeat (2) @(negedge sys_clk);
  endtask
  // Lower-level clear; wrong pulses the other level's clear instead
  task automatic clr(int b, logic wrong);
    @(posedge sys_clk);
    if (wrong && b == BIT_EXT_PIN) l2c <= '1;
    else if (wrong) pinClr <= 8'hff;
    else if (b < 4) l2c[b] <= 1'b1;
    else if (b == BIT_TIMER_TRAP) l2c.timerTrapClear <= 1'b1;
    else if (b == BIT_SIO_IRQ) l2c.sioIrqClear <= 1'b1;
    else pinClr <= pat;
    @(posedge sys_clk);
    l2c <= '0;
    pinClr <= 8'h00;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdx(OFS_STATUS_TOP, 16'h0);
    host_u.cfg(3'b011);
    for (int b = 0; b < 15; b++) begin
      rs = xs(rs);
      pat = rs[15:8] | 8'h01;
      if (b == BIT_RSVD) continue;
      fire(b);
      smi(1'b1);
      if (b == BIT_EXT_PIN) chk("pinStatus", 16'(pinStatus), 16'(pat));
      rdx(OFS_STATUS_MIRROR | rs[0], 16'(1 << b));
      rdx(OFS_STATUS_TOP | rs[1], 16'(1 << b));
      if (MASK_READ_CLEAR[b]) rdx(OFS_STATUS_TOP, 16'h0);
      else begin
        rdx(OFS_STATUS_TOP, 16'(1 << b));
        clr(b, 1'b1);
        rdx(OFS_STATUS_TOP, 16'(1 << b));
        clr(b, 1'b0);
        rdx(OFS_STATUS_TOP, 16'h0);
      end
      smi(1'b0);
      $display("test %0d done", b);
    end
    // Disabled sources must stay silent
    host_u.cfg(3'b000);
    fire(BIT_VID_RETRACE);
    fire(BIT_VGA_TIMER);
    smi(1'b0);
    host_u.cfg(3'b100);
    rdx(OFS_STATUS_TOP, 16'h8000);
    rdx(8'h04 | rs[7:0], 16'h0);
    smi(1'b0);
    $display("test tail done");
    repeat (3) @(posedge sys_clk);
    final_report;
  end
  // Run needs a few hundred cycles; this cuts a hang short
  initial begin
    #50000;
    fail_count++;
    final_report;
  end
endmodule
